// File: dv/dpm_chk.sv
// port checker for the priority map
module dpm_chk (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // frames
    input wire logic frm_valid,
    input wire logic frm_is_ip,
    input wire logic prio_valid,
    input wire logic prio_from_map,
    input wire dpm_pkg::dpm_prio_t prio
);
    import dpm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    // ce low freezes the block, so no cycle-count property can hold across it
    default disable iff (srst || !ce);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_done; psel && penable && pready; endsequence
    AST_WAIT: assert property (s_wait |=> s_done) else $error("no answer");
    AST_ONCE: assert property (s_done |=> !pready) else $error("long ready");
    AST_RDW: assert property (psel && penable && pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("wide");
    AST_ERR: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
    AST_LAT: assert property (frm_valid |=> prio_valid) else $error("no prio");
    AST_ONLY: assert property (!frm_valid |=> !prio_valid) else $error("stray prio");
    AST_SRC: assert property (frm_valid |=> prio_from_map == $past(frm_is_ip)) else $error("src");
    AST_NIP: assert property (frm_valid && !frm_is_ip |=> prio == DPM_PRIO_NONE) else $error("nonip");
endmodule : dpm_chk
bind dpm_top dpm_chk i_dpm_chk (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid), .frm_is_ip(frm_is_ip),
    .prio_valid(prio_valid), .prio_from_map(prio_from_map), .prio(prio));

// File: dv/dpm_tb_top.sv
// self-checking bench for the priority map
module dpm_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dpm_pkg::*;
    logic clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, fv = 0, fip = 0, pready, pslverr, pv, pm, er;
    logic [11:0] paddr = '0;
    logic [7:0] tos = '0;
    logic [31:0] pwdata = '0, prdata, rd, lf = 32'h00017574;
    logic [127:0] emap = '0;
    dpm_prio_t prio;
    int err_total = 0, checked = 0, cyc = 0;
    always #5 clk = ~clk;
    dpm_top i_dpm_top (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(fv),
        .frm_is_ip(fip), .frm_tos(tos), .prio_valid(pv), .prio_from_map(pm), .prio(prio));
    function automatic logic [31:0] ep(logic ip, logic [7:0] t);
        return ip ? {30'h0, emap[t[7:2]*2 +: 2]} : 32'h0;
    endfunction : ep
    task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic conclude();
        if (err_total == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    // index to byte address; the request stays put until pready is sampled
    task automatic apb(logic w, logic [7:0] ix, logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 12'({ix, 2'b00}), d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic frame(logic ip, logic [7:0] t);
        @(posedge clk);
        {fv, fip, tos} <= {1'b1, ip, t};
        @(posedge clk);
        fv <= 0;
        @(posedge clk);
        cmp("prio_valid", 1, pv);
        cmp("prio_from_map", ip, pm);
        cmp("prio", ep(ip, t), prio);
    endtask : frame
    initial begin
        logic [3:0] k;
        repeat (10) @(posedge clk);
        srst <= 0;
        for (int i = 0; i < 16; i++) begin
            apb(0, 8'(DPM_IDX_MAP_0 + i), 0);
            cmp("reset", 0, rd);
        end
        for (int i = 0; i < 60; i++) begin
            lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            k = lf[11:8];
            apb(1, DPM_IDX_MAP_0 + k, lf);
            emap[k*8 +: 8] = lf[7:0];
            // frame right behind the write must see the new entry
            frame(lf[16], {k, lf[27:24]});
            apb(0, DPM_IDX_MAP_0 + k, 0);
            cmp("readback", {24'h0, emap[k*8 +: 8]}, rd);
            cmp("readback_err", 0, er);
        end
        apb(1, DPM_IDX_MAP_12, 32'hE4);
        emap[96 +: 8] = 8'hE4;
        apb(1, 8'h40, 32'hFF);
        cmp("unmapped", 1, er);
        apb(0, 8'h40, 0);
        cmp("unmapped_rd_err", 1, er);
        cmp("unmapped_rd", 0, rd);
        for (int c = 0; c < 64; c++) frame(1, {6'(c), 2'b11});
        // ce low must hold the answer that is standing
        @(posedge clk);
        {fv, fip, tos} <= {1'b1, 1'b1, 8'hC0};
        @(posedge clk);
        {fv, ce} <= 2'b00;
        repeat (2) @(posedge clk);
        cmp("frozen_prio_valid", 1, pv);
        ce <= 1;
        // a reset in mid-run must clear a programmed map
        srst <= 1;
        repeat (2) @(posedge clk);
        srst <= 0;
        for (int i = 0; i < 16; i++) begin
            apb(0, 8'(DPM_IDX_MAP_0 + i), 0);
            cmp("rereset", 0, rd);
        end
        conclude();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
endmodule : dpm_tb_top

// File: src/dpm_lookup.sv
// full decode of a 6-bit code into its 2-bit map entry
module dpm_lookup (
    // map and code in, entry out
    dpm_lookup_if.lut lk
);
    import dpm_pkg::*;

    // each code owns bits [2*code+1 : 2*code]
    always_comb begin
        lk.entry = lk.map[{lk.code, 1'b0} +: DPM_PRIO_W];
    end
endmodule : dpm_lookup

// File: src/dpm_lookup_if.sv
// carrier between the map store and its lookup decoder
interface dpm_lookup_if;
    logic [dpm_pkg::DPM_MAP_BITS-1:0] map;
    dpm_pkg::dpm_code_t code;
    dpm_pkg::dpm_prio_t entry;
    modport store (output map, output code, input entry);
    modport lut (input map, input code, output entry);
endinterface : dpm_lookup_if

// File: src/dpm_pkg.sv
// constants for the diffserv priority map register bank
package dpm_pkg;
    // the register index is the map offset; the byte address is four times it
    localparam logic [7:0] DPM_IDX_MAP_0 = 8'h60;
    localparam logic [7:0] DPM_IDX_MAP_6 = 8'h66;
    localparam logic [7:0] DPM_IDX_MAP_7 = 8'h67;
    localparam logic [7:0] DPM_IDX_MAP_8 = 8'h68;
    localparam logic [7:0] DPM_IDX_MAP_9 = 8'h69;
    localparam logic [7:0] DPM_IDX_MAP_10 = 8'h6A;
    localparam logic [7:0] DPM_IDX_MAP_11 = 8'h6B;
    localparam logic [7:0] DPM_IDX_MAP_12 = 8'h6C;
    localparam logic [7:0] DPM_IDX_MAP_15 = 8'h6F;
    localparam int DPM_MAP_REGS = 16;
    localparam int DPM_CODE_W = 6;
    localparam int DPM_PRIO_W = 2;
    localparam int DPM_MAP_BITS = 128;
    localparam int DPM_ENTRIES_PER_REG = 4;
    // code field position inside the tos / traffic class byte
    localparam int DPM_TOS_CODE_MSB = 7;
    localparam int DPM_TOS_CODE_LSB = 2;
    localparam logic [7:0] DPM_MAP_RESET = 8'h00;
    localparam logic [1:0] DPM_PRIO_NONE = 2'h0;

    typedef logic [DPM_CODE_W-1:0] dpm_code_t;
    typedef logic [DPM_PRIO_W-1:0] dpm_prio_t;
endpackage : dpm_pkg

// File: src/dpm_top.sv
// diffserv code to frame priority map with apb register access
//Function
//- ip frame priority is the map entry chosen by tos bits 7 to 2
//- four 2-bit entries per register; 0x66 holds codes 0x18..0x1B, lowest in bits 1-0
//- each next register covers next four codes; 0x67 holds 0x1C..0x1F
//- register 0x6C holds codes 0x30..0x33; 0x33 in bits 7-6, 0x31 in 3-2
//- all entries reset to zero
//- entries read back what was written; frames after a write use it
//- the whole map is 128 bits, one 2-bit entry per 6-bit code
//
// Our own choice: the APB interface to the registers.
module dpm_top #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame classification request
    input wire logic frm_valid,
    input wire logic frm_is_ip,
    input wire logic [7:0] frm_tos,
    // classification answer
    output logic prio_valid,
    output logic prio_from_map,
    output dpm_pkg::dpm_prio_t prio
);
    import dpm_pkg::*;

    // the word index must reach the top map register
    if (ADDR_W < 10) begin : g_bad_addr_w
        $error("dpm_top: ADDR_W must be at least 10");
    end

    logic [7:0] map_reg [DPM_MAP_REGS];
    logic [7:0] next_map_reg [DPM_MAP_REGS];
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_prio_valid;
    logic next_prio_from_map;
    dpm_prio_t next_prio;
    logic access;
    logic [3:0] slot;

    dpm_lookup_if lk ();

    dpm_lookup u_lookup (
        .lk(lk)
    );

    // true when the byte address lands on a map register word
    function automatic logic dpm_reg_hit(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] widx;
        widx = addr[ADDR_W-1:2];
        return (addr[1:0] == 2'h0) && (widx >= (ADDR_W-2)'(DPM_IDX_MAP_0))
            && (widx <= (ADDR_W-2)'(DPM_IDX_MAP_15));
    endfunction : dpm_reg_hit

    // register slot inside the map, valid only on a hit
    function automatic logic [3:0] dpm_reg_slot(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] off;
        off = addr[ADDR_W-1:2] - (ADDR_W-2)'(DPM_IDX_MAP_0);
        return off[3:0];
    endfunction : dpm_reg_slot

    // map registers flattened so code n sits at bits 2n+1:2n; register 0x66
    // lands on codes 0x18..0x1B, 0x67 on 0x1C..0x1F, 0x6C on 0x30..0x33
    always_comb begin
        for (int i = 0; i < DPM_MAP_REGS; i++) begin
            lk.map[i*8 +: 8] = map_reg[i];
        end
        lk.code = frm_tos[DPM_TOS_CODE_MSB:DPM_TOS_CODE_LSB];
    end

    assign access = psel && penable && pready;
    assign slot = dpm_reg_slot(paddr);

    always_comb begin
        for (int i = 0; i < DPM_MAP_REGS; i++) begin
            next_map_reg[i] = map_reg[i];
        end
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_pready = 1'b0;
        // one wait state: answer is prepared in the first access cycle
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_pslverr = !dpm_reg_hit(paddr);
            next_prdata = 32'h0000_0000;
            if (!pwrite && dpm_reg_hit(paddr)) begin
                next_prdata = {24'h00_0000, map_reg[slot]};
            end
        end
        // writes land only on the completing edge; unmapped writes are dropped
        if (access && pwrite && dpm_reg_hit(paddr)) begin
            next_map_reg[slot] = pwdata[7:0];
        end
        if (srst) begin
            for (int i = 0; i < DPM_MAP_REGS; i++) begin
                next_map_reg[i] = DPM_MAP_RESET;
            end
            next_prdata = 32'h0000_0000;
            next_pready = 1'b0;
            next_pslverr = 1'b0;
        end
    end

    // answer one cycle after the request, from the map as it stands in the request cycle; a write landing on the answering edge is not seen
    always_comb begin
        next_prio_valid = frm_valid;
        next_prio_from_map = frm_valid && frm_is_ip;
        next_prio = DPM_PRIO_NONE;
        if (frm_valid && frm_is_ip) begin
            next_prio = lk.entry;
        end
        if (srst) begin
            next_prio_valid = 1'b0;
            next_prio_from_map = 1'b0;
            next_prio = DPM_PRIO_NONE;
        end
    end

    // ce low freezes everything, reset included, so keep ce high through reset
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int i = 0; i < DPM_MAP_REGS; i++) begin
                map_reg[i] <= next_map_reg[i];
            end
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prio_valid <= next_prio_valid;
            prio_from_map <= next_prio_from_map;
            prio <= next_prio;
        end
    end
endmodule : dpm_top
